// *** core/ccs_pkg.sv ***
// Constants and types for the clock start status and slow-clock source select block.
// Assumes an APB slave port with 32-bit data and byte addresses.
//
// Overview of operation
// - A read-only bit reads 1 once the fast-clock start task has been triggered and 0 before that.
// - A read-only bit reads 1 once the slow-clock start task has been triggered.
// - Triggering the slow-clock start task copies the source select register into a read-only snapshot.
// - The source choice field codes 0 as RC oscillator, 1 as crystal and 2 as synthesized from the fast clock.
// - A read-write bypass bit set to 1 lets a rail-to-rail external clock drive the slow clock.
// - A read-write external bit set to 1 selects an external source, taking effect only with the crystal code.
// - The calibration interval register keeps its value across ordinary resets.
// - The calibration interval covers 0.25 s up to 31.75 s.
package ccs_pkg;
   localparam logic [11:0] FAST_START_TASK_OFS = 12'h000;
   localparam logic [11:0] SLOW_START_TASK_OFS = 12'h008;
   localparam logic [11:0] FAST_START_FLAG_OFS = 12'h408;
   localparam logic [11:0] FAST_STATE_OFS = 12'h40C;
   localparam logic [11:0] SLOW_START_FLAG_OFS = 12'h414;
   localparam logic [11:0] SLOW_STATE_OFS = 12'h418;
   localparam logic [11:0] SLOW_SNAPSHOT_OFS = 12'h41C;
   localparam logic [11:0] SLOW_SELECT_OFS = 12'h518;
   localparam logic [11:0] CALIB_INTERVAL_OFS = 12'h538;
   // Source select layout
   localparam int SRC_LSB = 0;
   localparam int BYPASS_BIT = 16;
   localparam int EXTERNAL_BIT = 17;
   localparam logic [1:0] SRC_RC = 2'h0;
   localparam logic [1:0] SRC_XTAL = 2'h1;
   localparam logic [1:0] SRC_SYNTH = 2'h2;
   // Calibration interval: 7-bit count of quarter seconds, 1..127
   localparam int CALIB_W = 7;
   localparam logic [6:0] CALIB_MIN = 7'h01;
   localparam logic [6:0] CALIB_MAX = 7'h7F;
   localparam logic [6:0] CALIB_RESET = 7'h01;
   localparam int QUARTER_SEC_MS = 250;
   localparam int CLK_HZ = 10000000;
   localparam int QUARTER_SEC_CYCLES = CLK_HZ / 1000 * QUARTER_SEC_MS;
   localparam logic [31:0] RESET_WORD = 32'h00000000;

   typedef struct packed {
      logic external_src;
      logic bypass;
      logic [1:0] source_choice;
   } ccs_select_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } ccs_apb_req_t;
endpackage

// *** core/ccs_clock_ctrl.sv ***
// Clock start status, slow-clock source select and calibration timer, APB slave.
// Assumes one 10 MHz clock; the retention reset is kept low only on power-up.
`timescale 1ns/1ns
module ccs_clock_ctrl
   import ccs_pkg::*;
#(
   parameter int QUARTER_CYCLES = QUARTER_SEC_CYCLES
) (
   // Clock and resets
   input wire logic REF_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic RETAIN_RESET_N_IN,
   input wire logic CLK_EN_IN,
   // APB slave
   input wire ccs_apb_req_t APB_REQ_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Clock state from the oscillators
   input wire logic FAST_RUNNING_IN,
   input wire logic SLOW_RUNNING_IN,
   // Control to the clock tree
   output logic FAST_START_OUT,
   output logic SLOW_START_OUT,
   output ccs_select_t SLOW_SELECT_OUT,
   output logic CALIB_TIMEOUT_OUT
);
   // The quarter-second counter needs at least one cycle per quarter
   if (QUARTER_CYCLES < 1) begin : g_bad_quarter
      $error("QUARTER_CYCLES must be at least 1");
   end

   // Pin inputs pass three flops; a change counts once stages two and three agree
   logic [2:0] fast_sync_q, slow_sync_q;
   logic fast_state_q, fast_state_d, slow_state_q, slow_state_d;

   logic fast_flag_q, fast_flag_d, slow_flag_q, slow_flag_d;
   logic fast_start_q, fast_start_d, slow_start_q, slow_start_d;
   ccs_select_t select_q, select_d, snap_q, snap_d;
   logic [CALIB_W-1:0] calib_q, calib_d;
   logic [31:0] qcnt_q, qcnt_d;
   logic [CALIB_W-1:0] tick_q, tick_d;
   logic timeout_q, timeout_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;

   logic access, wr, rd, hit;
   logic [31:0] rword;

   always_comb begin
      access = APB_REQ_IN.psel && APB_REQ_IN.penable && !pready_q;
      wr = access && APB_REQ_IN.pwrite;
      rd = access && !APB_REQ_IN.pwrite;
      fast_state_d = (fast_sync_q[2] == fast_sync_q[1]) ? fast_sync_q[2] : fast_state_q;
      slow_state_d = (slow_sync_q[2] == slow_sync_q[1]) ? slow_sync_q[2] : slow_state_q;
      hit = 1'b1;
      rword = RESET_WORD;
      case (APB_REQ_IN.paddr)
         FAST_START_TASK_OFS, SLOW_START_TASK_OFS: rword = RESET_WORD;
         FAST_START_FLAG_OFS: rword[0] = fast_flag_q;
         FAST_STATE_OFS: rword[0] = fast_state_q;
         SLOW_START_FLAG_OFS: rword[0] = slow_flag_q;
         SLOW_STATE_OFS: rword[0] = slow_state_q;
         SLOW_SNAPSHOT_OFS: begin
            rword[SRC_LSB +: 2] = snap_q.source_choice;
            rword[BYPASS_BIT] = snap_q.bypass;
            rword[EXTERNAL_BIT] = snap_q.external_src;
         end
         SLOW_SELECT_OFS: begin
            rword[SRC_LSB +: 2] = select_q.source_choice;
            rword[BYPASS_BIT] = select_q.bypass;
            rword[EXTERNAL_BIT] = select_q.external_src;
         end
         CALIB_INTERVAL_OFS: rword[CALIB_W-1:0] = calib_q;
         default: hit = 1'b0;
      endcase
      pready_d = access;
      pslverr_d = access && !hit;
      prdata_d = rd ? rword : RESET_WORD;
   end

   // Task pulses, status flags, select and snapshot
   always_comb begin
      fast_start_d = 1'b0;
      slow_start_d = 1'b0;
      fast_flag_d = fast_flag_q;
      slow_flag_d = slow_flag_q;
      select_d = select_q;
      snap_d = snap_q;
      if (wr && APB_REQ_IN.paddr == FAST_START_TASK_OFS && APB_REQ_IN.pwdata[0]) begin
         fast_start_d = 1'b1;
         fast_flag_d = 1'b1;
      end
      if (wr && APB_REQ_IN.paddr == SLOW_START_TASK_OFS && APB_REQ_IN.pwdata[0]) begin
         slow_start_d = 1'b1;
         slow_flag_d = 1'b1;
         snap_d = select_q;
      end
      if (wr && APB_REQ_IN.paddr == SLOW_SELECT_OFS) begin
         select_d.source_choice = APB_REQ_IN.pwdata[SRC_LSB +: 2];
         select_d.bypass = APB_REQ_IN.pwdata[BYPASS_BIT];
         select_d.external_src = APB_REQ_IN.pwdata[EXTERNAL_BIT];
      end
   end

   // Calibration interval and quarter-second timer
   always_comb begin
      calib_d = calib_q;
      qcnt_d = qcnt_q;
      tick_d = tick_q;
      timeout_d = 1'b0;
      if (wr && APB_REQ_IN.paddr == CALIB_INTERVAL_OFS) begin
         // Counts below the minimum are raised to it; write bits above bit 6 are dropped
         if (APB_REQ_IN.pwdata[CALIB_W-1:0] < CALIB_MIN) begin
            calib_d = CALIB_MIN;
         end else begin
            calib_d = APB_REQ_IN.pwdata[CALIB_W-1:0];
         end
      end
      if (qcnt_q >= 32'(QUARTER_CYCLES - 1)) begin
         qcnt_d = 32'h00000000;
         if (tick_q + 7'h01 >= calib_q) begin
            tick_d = 7'h00;
            timeout_d = 1'b1;
         end else begin
            tick_d = tick_q + 7'h01;
         end
      end else begin
         qcnt_d = qcnt_q + 32'h00000001;
      end
   end

   // Retained domain: only the retention reset loads it, with CALIB_RESET
   always_ff @(posedge REF_CLK_IN) begin
      if (!RETAIN_RESET_N_IN) begin
         calib_q <= CALIB_RESET;
      end else if (CLK_EN_IN) begin
         calib_q <= calib_d;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESET_N_IN) begin
         fast_sync_q <= 3'h0;
         slow_sync_q <= 3'h0;
         fast_state_q <= 1'b0;
         slow_state_q <= 1'b0;
         fast_flag_q <= 1'b0;
         slow_flag_q <= 1'b0;
         fast_start_q <= 1'b0;
         slow_start_q <= 1'b0;
         select_q <= '0;
         snap_q <= '0;
         qcnt_q <= 32'h00000000;
         tick_q <= 7'h00;
         timeout_q <= 1'b0;
         prdata_q <= RESET_WORD;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (CLK_EN_IN) begin
         fast_sync_q <= {fast_sync_q[1:0], FAST_RUNNING_IN};
         slow_sync_q <= {slow_sync_q[1:0], SLOW_RUNNING_IN};
         fast_state_q <= fast_state_d;
         slow_state_q <= slow_state_d;
         fast_flag_q <= fast_flag_d;
         slow_flag_q <= slow_flag_d;
         fast_start_q <= fast_start_d;
         slow_start_q <= slow_start_d;
         select_q <= select_d;
         snap_q <= snap_d;
         qcnt_q <= qcnt_d;
         tick_q <= tick_d;
         timeout_q <= timeout_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   always_comb begin
      PRDATA_OUT = prdata_q;
      PREADY_OUT = pready_q;
      PSLVERR_OUT = pslverr_q;
      FAST_START_OUT = fast_start_q;
      SLOW_START_OUT = slow_start_q;
      SLOW_SELECT_OUT = select_q;
      CALIB_TIMEOUT_OUT = timeout_q;
   end
endmodule

// *** bench/ccs_assertions.sv ***
// Checker for bus answers and start pulses of the clock control block.
// Assumes one clock; bound to the top module below.
`timescale 1ns/1ns
module ccs_assertions
   import ccs_pkg::*;
(
   // Clock, reset and bus
   input wire logic REF_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic CLK_EN_IN,
   input wire ccs_apb_req_t APB_REQ_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   // Task pulses
   input wire logic FAST_START_OUT,
   input wire logic SLOW_START_OUT
);
   logic acc;
   logic wr1;
   assign acc = APB_REQ_IN.psel & APB_REQ_IN.penable & ~PREADY_OUT & CLK_EN_IN;
   assign wr1 = acc & APB_REQ_IN.pwrite & APB_REQ_IN.pwdata[0];
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   a_answer_follows: assert property (acc |=> PREADY_OUT) else $error("no answer");
   a_answer_single: assert property (PREADY_OUT && CLK_EN_IN |=> !PREADY_OUT)
      else $error("long answer");
   a_fast_pulse: assert property (wr1 && APB_REQ_IN.paddr == FAST_START_TASK_OFS |=> FAST_START_OUT)
      else $error("fast start missing");
   a_slow_pulse: assert property (wr1 && APB_REQ_IN.paddr == SLOW_START_TASK_OFS |=> SLOW_START_OUT)
      else $error("slow start missing");
   a_fast_cause: assert property (FAST_START_OUT |-> $past(wr1 && APB_REQ_IN.paddr == FAST_START_TASK_OFS))
      else $error("stray fast start");
   a_slow_once: assert property (SLOW_START_OUT && CLK_EN_IN |=> !SLOW_START_OUT)
      else $error("long start");
   a_slow_cause: assert property (SLOW_START_OUT |-> $past(wr1 && APB_REQ_IN.paddr == SLOW_START_TASK_OFS))
      else $error("stray slow start");
   a_error_zero: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0)
      else $error("bad error answer");
   a_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("data outside answer");
endmodule

bind ccs_clock_ctrl ccs_assertions i_ccs_assertions (.REF_CLK_IN, .RESET_N_IN, .CLK_EN_IN, .APB_REQ_IN,
   .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .FAST_START_OUT, .SLOW_START_OUT);

// *** bench/testbench.sv ***
// Self-checking bench for the clock control block over APB.
// Assumes the bound checker and a short quarter-second count.
`timescale 1ns/1ns
module testbench;
   import ccs_pkg::*;
   logic clk = 0, rst_n = 0, ret_n = 0, en = 1, tmo, rdy, err, fs, ss;
   ccs_apb_req_t req = '0;
   logic [31:0] rdata, lfsr = 32'hA56CB6DB;
   ccs_select_t sel;
   logic [32:0] expq[$];
   int errors = 0, compares = 0;
   ccs_clock_ctrl #(.QUARTER_CYCLES(4)) i_ccs_clock_ctrl (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
      .RETAIN_RESET_N_IN(ret_n), .CLK_EN_IN(en), .APB_REQ_IN(req), .PRDATA_OUT(rdata), .PREADY_OUT(rdy),
      .PSLVERR_OUT(err), .FAST_RUNNING_IN(1'b1), .SLOW_RUNNING_IN(1'b0), .FAST_START_OUT(fs),
      .SLOW_START_OUT(ss), .SLOW_SELECT_OUT(sel), .CALIB_TIMEOUT_OUT(tmo));
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] rnd(input logic [31:0] v);
      rnd = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
      int n;
      @(posedge clk);
      expq.push_back(e);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
      if (n >= 20) begin errors++; report_and_stop(); end
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0, {1'b0, e});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 33'h0);
   endtask
   // Answer watcher takes the oldest expectation
   always @(posedge clk)
      if (rdy === 1'b1) chk({err, rdata}, expq.size() ? expq.pop_front() : 33'h1FFFFFFFF);
   initial begin
      logic [31:0] v;
      int k, n;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      ret_n <= 1'b1;
      rd(FAST_START_FLAG_OFS, 32'h0);
      rd(SLOW_START_FLAG_OFS, 32'h0);
      rd(SLOW_SNAPSHOT_OFS, 32'h0);
      rd(SLOW_SELECT_OFS, 32'h0);
      rd(CALIB_INTERVAL_OFS, 32'h1);
      rd(FAST_STATE_OFS, 32'h1);
      bus(12'h100, 1'b0, 32'h0, {1'b1, 32'h0});
      wr(FAST_START_TASK_OFS, 32'h1);
      wr(FAST_START_FLAG_OFS, 32'h0);
      rd(FAST_START_FLAG_OFS, 32'h1);
      // Frozen clock enable must keep the fast-start flag
      en <= 1'b0;
      repeat (5) @(posedge clk);
      en <= 1'b1;
      rd(FAST_START_FLAG_OFS, 32'h1);
      $display("reset and flag test done");
      for (k = 0; k < 3; k++) begin
         lfsr = rnd(lfsr);
         v = {14'h0, lfsr[1:0], 14'h0, k[1:0]};
         wr(SLOW_SELECT_OFS, v);
         rd(SLOW_SELECT_OFS, v);
         chk({29'h0, sel}, {29'h0, lfsr[1:0], k[1:0]});
         wr(SLOW_START_TASK_OFS, 32'h1);
         rd(SLOW_SNAPSHOT_OFS, v);
         wr(SLOW_SELECT_OFS, ~v & 32'h00030003);
         rd(SLOW_SNAPSHOT_OFS, v);
      end
      rd(SLOW_START_FLAG_OFS, 32'h1);
      $display("source test done");
      wr(CALIB_INTERVAL_OFS, 32'h0);
      rd(CALIB_INTERVAL_OFS, 32'h1);
      wr(CALIB_INTERVAL_OFS, 32'h7F);
      rd(CALIB_INTERVAL_OFS, 32'h7F);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(CALIB_INTERVAL_OFS, 32'h7F);
      wr(CALIB_INTERVAL_OFS, 32'h2);
      for (k = 0; k < 3; k++) begin
         n = 0;
         do begin @(negedge clk); n++; end while (tmo !== 1'b1 && n < 600);
      end
      chk(33'(n), 33'h8);
      $display("calibration test done");
      report_and_stop();
   end
endmodule
